// file: design/bdx_defs.vh
`ifndef BDX_DEFS_VH
`define BDX_DEFS_VH

// Register byte offsets
`define BDX_OFS_CMD 12'h000
`define BDX_OFS_WREG 12'h004
`define BDX_OFS_FLAGS 12'h008
`define BDX_OFS_BANK 12'h00c
`define BDX_OFS_STAT 12'h010
`define BDX_OFS_MEM 12'h400

// Command register fields
`define BDX_CMD_F_LSB 0
`define BDX_CMD_F_MSB 7
`define BDX_CMD_DEST_BIT 8
`define BDX_CMD_ACC_BIT 9
`define BDX_CMD_OP_BIT 10

// Flag register bit positions
`define BDX_FLG_C 0
`define BDX_FLG_DC 1
`define BDX_FLG_Z 2
`define BDX_FLG_OV 3
`define BDX_FLG_N 4

// Status register bit positions
`define BDX_STAT_BUSY 0
`define BDX_STAT_RES_LSB 8

// Reset values
`define BDX_RST_WREG 8'h00
`define BDX_RST_FLAGS 5'h00
`define BDX_RST_BANK 2'h0

// Operation codes
`define BDX_OP_FILE_DECREMENT_OP 1'b0
`define BDX_OP_DAW 1'b1

// Decimal adjust constants
`define BDX_BCD_MAX 4'h9
`define BDX_BCD_FIX 4'h6

// Access bank split and its upper bank
`define BDX_ACC_SPLIT 8'h80
`define BDX_ACC_HIGH_BANK 2'h3

// Phases of one instruction cycle
`define BDX_PH_Q1 2'h0
`define BDX_PH_Q2 2'h1
`define BDX_PH_Q3 2'h2
`define BDX_PH_Q4 2'h3

`endif

// file: design/bdx_alu.v
`timescale 1ns/1ps
`include "bdx_defs.vh"

module bdx_alu (
    // Operation select and operand
    input wire i_op,
    input wire [7:0] i_opnd,
    // Incoming flags
    input wire [4:0] i_flags,
    // Result and updated flags
    output reg [7:0] o_res,
    output reg [4:0] o_flags
);
    reg lo_adj;
    reg hi_adj;
    reg [8:0] lo_sum;
    reg [8:0] hi_sum;
    reg [7:0] dec;

    always @* begin
        o_flags = i_flags;
        lo_adj = (i_opnd[3:0] > `BDX_BCD_MAX) || i_flags[`BDX_FLG_DC];
        lo_sum = {1'b0, i_opnd} + {5'h00, (lo_adj ? `BDX_BCD_FIX : 4'h0)};
        // high nibble fix, low carry folded in
        hi_adj = (lo_sum[7:4] > `BDX_BCD_MAX) || i_flags[`BDX_FLG_C] || lo_sum[8];
        hi_sum = {1'b0, lo_sum[7:0]} + {1'b0, (hi_adj ? `BDX_BCD_FIX : 4'h0), 4'h0};
        dec = i_opnd - 8'h01;
        if (i_op == `BDX_OP_DAW) begin
            o_res = hi_sum[7:0];
            o_flags[`BDX_FLG_C] = i_flags[`BDX_FLG_C] | lo_sum[8] | hi_sum[8];
        end else begin
            o_res = dec;
            o_flags[`BDX_FLG_C] = (i_opnd != 8'h00);
            o_flags[`BDX_FLG_DC] = (i_opnd[3:0] != 4'h0);
            o_flags[`BDX_FLG_Z] = (dec == 8'h00);
            o_flags[`BDX_FLG_OV] = (i_opnd == 8'h80);
            o_flags[`BDX_FLG_N] = dec[7];
        end
    end
endmodule // bdx_alu

// file: design/bdx_exec.v
// Notes on behaviour
// - Adjust adds six to low nibble when above nine or digit carry set.
// - Adjust adds six to high nibble when above nine or carry set.
// - Adjust changes only carry, digit carry kept; carry may become set.
// - Adjust takes no operand, corrects working register in place.
// - Decrement subtracts one; destination bit 0 to working reg, 1 back.
// - Access bit 0 forces access bank; 1 uses bank pointer.
// - Decrement: one word, decode, read, process, write over four phases.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "bdx_defs.vh"

module bdx_exec (
    // Clock, reset, enable
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire i_ce,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg o_pready,
    output reg [31:0] o_prdata,
    output reg o_pslverr,
    // Core status
    output reg o_busy,
    output reg [1:0] o_phase
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ARMED = 2'h1;
    localparam ST_RUN = 2'h2;

    reg [7:0] file_mem [0:1023];
    reg [7:0] wreg;
    reg [4:0] flags;
    reg [1:0] bank_ptr;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [10:0] cmd;
    reg [9:0] ex_addr;
    reg [7:0] opnd;
    reg [7:0] res;
    reg [4:0] res_flags;
    reg [7:0] last_res;
    reg [31:0] rd_val;
    reg rd_err;
    reg [9:0] next_addr;

    wire setup = i_psel & ~i_penable;
    wire wr_ok = i_psel & i_penable & o_pready & i_pwrite;
    wire mem_hit = (i_paddr >= `BDX_OFS_MEM);
    wire [9:0] mem_idx = i_paddr[11:2] - 10'h100;
    wire cmd_wr = wr_ok & (i_paddr == `BDX_OFS_CMD);
    wire [7:0] alu_res;
    wire [4:0] alu_flags;

    bdx_alu u_alu (
        .i_op(cmd[`BDX_CMD_OP_BIT]),
        .i_opnd(opnd),
        .i_flags(flags),
        .o_res(alu_res),
        .o_flags(alu_flags)
    );

    // Bank resolution for the file operand
    always @* begin
        if (!cmd[`BDX_CMD_ACC_BIT]) begin
            if (cmd[7:0] < `BDX_ACC_SPLIT) begin
                next_addr = {2'h0, cmd[7:0]};
            end else begin
                next_addr = {`BDX_ACC_HIGH_BANK, cmd[7:0]};
            end
        end else begin
            next_addr = {bank_ptr, cmd[7:0]};
        end
    end

    // Read mux for the register bus
    always @* begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        if (mem_hit) begin
            rd_val = {24'h00_0000, file_mem[mem_idx]};
        end else begin
            case (i_paddr)
                `BDX_OFS_CMD: rd_val = {21'h00_0000, cmd};
                `BDX_OFS_WREG: rd_val = {24'h00_0000, wreg};
                `BDX_OFS_FLAGS: rd_val = {27'h000_0000, flags};
                `BDX_OFS_BANK: rd_val = {30'h0000_0000, bank_ptr};
                `BDX_OFS_STAT: rd_val = {16'h0000, last_res, 7'h00, o_busy};
                default: rd_err = 1'b1;
            endcase
        end
    end

    // Sequencer: a command waits for the next Q1
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cmd_wr) begin
                    next_state = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (o_phase == `BDX_PH_Q4) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (o_phase == `BDX_PH_Q4) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // APB answer: data captured in setup, ready in access
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (i_ce) begin
            o_pready <= setup;
            if (setup) begin
                o_prdata <= i_pwrite ? 32'h0000_0000 : rd_val;
                o_pslverr <= rd_err;
            end else begin
                o_pslverr <= 1'b0;
            end
        end
    end

    // Phase counter and execution
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_phase <= `BDX_PH_Q1;
            state <= ST_IDLE;
            o_busy <= 1'b0;
            cmd <= 11'h000;
            ex_addr <= 10'h000;
            opnd <= 8'h00;
            res <= 8'h00;
            res_flags <= `BDX_RST_FLAGS;
            last_res <= 8'h00;
        end else if (i_ce) begin
            o_phase <= o_phase + 2'h1;
            state <= next_state;
            o_busy <= (next_state != ST_IDLE);
            if (cmd_wr && state == ST_IDLE) begin
                cmd <= i_pwdata[10:0];
            end
            if (state == ST_RUN) begin
                case (o_phase)
                    `BDX_PH_Q1: ex_addr <= next_addr;
                    `BDX_PH_Q2: begin
                        if (cmd[`BDX_CMD_OP_BIT] == `BDX_OP_DAW) begin
                            opnd <= wreg;
                        end else begin
                            opnd <= file_mem[ex_addr];
                        end
                    end
                    `BDX_PH_Q3: begin
                        res <= alu_res;
                        res_flags <= alu_flags;
                    end
                    `BDX_PH_Q4: last_res <= res;
                    default: last_res <= last_res;
                endcase
            end
        end
    end

    // Architectural state; the executing write wins over the bus
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            wreg <= `BDX_RST_WREG;
            flags <= `BDX_RST_FLAGS;
            bank_ptr <= `BDX_RST_BANK;
        end else if (i_ce) begin
            if (wr_ok && i_paddr == `BDX_OFS_WREG) begin
                wreg <= i_pwdata[7:0];
            end
            if (wr_ok && i_paddr == `BDX_OFS_FLAGS) begin
                flags <= i_pwdata[4:0];
            end
            if (wr_ok && i_paddr == `BDX_OFS_BANK) begin
                bank_ptr <= i_pwdata[1:0];
            end
            if (state == ST_RUN && o_phase == `BDX_PH_Q4) begin
                flags <= res_flags;
                if (cmd[`BDX_CMD_OP_BIT] == `BDX_OP_DAW || !cmd[`BDX_CMD_DEST_BIT]) begin
                    wreg <= res;
                end
            end
        end
    end

    // File memory, no reset
    always @(posedge i_ref_clk) begin
        if (i_ce) begin
            // write back in the last phase
            if (state == ST_RUN && o_phase == `BDX_PH_Q4
                && cmd[`BDX_CMD_OP_BIT] == `BDX_OP_FILE_DECREMENT_OP && cmd[`BDX_CMD_DEST_BIT]) begin
                file_mem[ex_addr] <= res;
            end else if (wr_ok && mem_hit) begin
                file_mem[mem_idx] <= i_pwdata[7:0];
            end
        end
    end
endmodule // bdx_exec

// file: test/bdx_exec_asserts.sv
`timescale 1ns/1ps
module bdx_exec_asserts (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire i_ce,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire o_pready,
    input wire o_pslverr,
    input wire o_busy,
    input wire [1:0] o_phase
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_setup;
        i_psel && !i_penable && i_ce;
    endsequence
    sequence s_run;
        o_busy [*4] ##[1:9] !o_busy;
    endsequence
    chk_phase_step: assert property (i_ce |=> o_phase == $past(o_phase) + 2'h1)
        else $error("phase counter did not step");
    chk_busy_start: assert property (i_psel && i_penable && o_pready && i_pwrite
        && i_paddr == 12'h000 && !o_busy |-> ##[1:2] o_busy)
        else $error("command did not start");
    chk_busy_run: assert property ($rose(o_busy) |-> s_run)
        else $error("busy span wrong");
    chk_ready_after: assert property (s_setup |=> o_pready)
        else $error("no answer after setup");
    chk_ready_cause: assert property (o_pready |-> $past(i_psel && !i_penable))
        else $error("answer without setup");
    chk_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("answer held too long");
    chk_err_unmap: assert property (s_setup ##0 i_paddr == 12'h014 |=> o_pslverr)
        else $error("unmapped not refused");
endmodule // bdx_exec_asserts
bind bdx_exec bdx_exec_asserts i_bdx_exec_asserts (.i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_busy(o_busy), .o_phase(o_phase));

// file: test/bdx_exec_tb_top.sv
`timescale 1ns/1ps
module bdx_exec_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rd;
    logic err;
    int err_count = 0;
    int checks_done = 0;
    always #50 clk = ~clk;
    bdx_exec i_bdx_exec (.i_ref_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .o_busy(), .o_phase());
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h010, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 20);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic t_adjust();
        logic [7:0] wi[5] = '{8'ha5, 8'hce, 8'h09, 8'h12, 8'h45};
        logic [4:0] fi[5] = '{5'h00, 5'h00, 5'h02, 5'h01, 5'h1c};
        logic [7:0] we[5] = '{8'h05, 8'h34, 8'h0f, 8'h72, 8'h45};
        logic [4:0] fe[5] = '{5'h01, 5'h01, 5'h02, 5'h01, 5'h1c};
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 12'h004, {24'h0, wi[i]});
            apb(1'b1, 12'h008, {27'h0, fi[i]});
            apb(1'b1, 12'h000, 32'h400);
            wait_idle();
            apb(1'b0, 12'h004, 32'h0);
            chk("adj_w", rd, {24'h0, we[i]}); // corrected value
            apb(1'b0, 12'h008, 32'h0);
            chk("adj_flags", rd, {27'h0, fe[i]}); // other flags kept
        end
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        $display("adjust test done");
    endtask
    task automatic t_decr();
        logic [1:0] bk[3] = '{2'h2, 2'h2, 2'h1};
        logic [7:0] fa[3] = '{8'h10, 8'h10, 8'h7f};
        // Access and destination bits
        logic [1:0] ad[3] = '{2'h3, 2'h0, 2'h3};
        logic [7:0] ini[3] = '{8'h01, 8'h80, 8'h00};
        logic [7:0] res[3] = '{8'h00, 8'h7f, 8'hff};
        logic [4:0] fe[3] = '{5'h07, 5'h09, 5'h10};
        logic [11:0] ma;
        for (int i = 0; i < 3; i++) begin
            ma = 12'h400 + {(ad[i][1] ? bk[i] : 2'h0), fa[i], 2'b00};
            apb(1'b1, 12'h00c, {30'h0, bk[i]});
            apb(1'b1, ma, {24'h0, ini[i]});
            apb(1'b1, 12'h004, 32'h55);
            apb(1'b1, 12'h000, {22'h0, ad[i], fa[i]});
            // Second start lands while busy and must be dropped
            apb(1'b1, 12'h000, {22'h0, ad[i], fa[i]});
            wait_idle();
            chk("stat_res", {24'h0, rd[15:8]}, {24'h0, res[i]}); // single run
            apb(1'b0, ma, 32'h0);
            chk("file", rd, {24'h0, ad[i][0] ? res[i] : ini[i]}); // file result
            apb(1'b0, 12'h004, 32'h0);
            chk("w", rd, {24'h0, ad[i][0] ? 8'h55 : res[i]}); // working result
            apb(1'b0, 12'h008, 32'h0);
            chk("dec_flags", rd, {27'h0, fe[i]}); // borrow flags
        end
        $display("decrement test done");
    endtask
    initial begin
        #500000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_adjust();
        t_decr();
        give_verdict();
    end
endmodule // bdx_exec_tb_top
